// *** design/ocfh_core.sv ***
// overcurrent counter, hiccup retry and cycle-adaptive dead time
//
// Behaviour
// - An overcurrent seen while the high-side drive is on ends that pulse and counts the 3-bit counter up.
// - A switching cycle with the high side on and no overcurrent counts the counter down by one.
// - The counter holds at seven on increment and at zero on decrement, never wrapping.
// - A count of seven enters the fault state and raises the fault output.
// - Entering fault turns both gate drives off, starts the cap discharge and takes one count off.
// - In fault, an empty cap ends discharge to let it charge, and the 1.3 V mark discharges again with a decrement.
// - The charge and discharge repeat, one decrement each, until the count is zero, six in all.
// - Zero count in fault clears the fault, re-enables the drives and restarts with a full soft-start.
// - During any soft-start pulses still end on overcurrent but no overcurrent is counted.
// - Both dead-time delays of each cycle are set from switch-node timing measured in the previous cycle.
// - High-side pulses narrower than 150 ns are flagged since the dead-time scheme may overlap there.
// - After a fault the cap recharges from the same source as at first start-up.
`default_nettype none
`include "ocfh_map.svh"
module ocfh_core
  import ocfh_pkg::*;
#(
  parameter int CNT_W = `OCFH_CNT_W,
  parameter int DT_W  = `OCFH_DT_W
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic cycle_start,
  input  wire logic pwm_end,
  input  wire logic overcurrent,
  input  wire logic softstart_cap_empty,
  input  wire logic softstart_cap_peak,
  input  wire logic softstart_cap_done,
  input  wire logic switch_node_low,
  input  wire logic switch_node_high,
  input  wire logic softstart_shutdown_pin,
  output logic      high_side_gate_drive,
  output logic      low_side_gate_drive,
  output logic      softstart_discharge,
  output logic      fault,
  output logic      softstart_active,
  output logic      narrow_pulse,
  output logic [CNT_W-1:0] oc_count
);

  // the map header fixes the counter and dead-time widths
  initial begin
    if (CNT_W != `OCFH_CNT_W || DT_W != `OCFH_DT_W)
      $error("ocfh_core: widths must match the map header");
  end

  localparam int MIN_PW_CYC = (`OCFH_MIN_PW_NS + `OCFH_CLK_NS - 1) / `OCFH_CLK_NS;

  ocfh_state_t st_reg;
  ocfh_state_t st_next;
  ocfh_sense_t sense_in;
  logic        start_pulse;
  logic        shut;
  logic        end_hs;
  logic [`OCFH_CNT_W-1:0] cnt_up;
  logic [`OCFH_CNT_W-1:0] cnt_dn;

  // raw comparator levels enter the two-stage synchroniser
  always_comb begin
    sense_in.cycle_start = cycle_start;
    sense_in.pwm_end     = pwm_end;
    sense_in.overcurrent = overcurrent;
    sense_in.ss_empty    = softstart_cap_empty;
    sense_in.ss_peak     = softstart_cap_peak;
    sense_in.ss_done     = softstart_cap_done;
    sense_in.sw_low      = switch_node_low;
    sense_in.sw_high     = switch_node_high;
    sense_in.shutdown    = ~softstart_shutdown_pin;
  end

  // saturating steps of the overcurrent counter
  assign cnt_up = (st_reg.count == `OCFH_CNT_FULL) ? st_reg.count : st_reg.count + `OCFH_CNT_ONE;
  assign cnt_dn = (st_reg.count == `OCFH_CNT_ZERO) ? st_reg.count : st_reg.count - `OCFH_CNT_ONE;

  assign start_pulse = st_reg.s2.cycle_start & ~st_reg.s2_start_d;
  assign shut        = st_reg.s2.shutdown;

  always_comb begin
    st_next            = st_reg;
    st_next.s1         = sense_in;
    st_next.s2         = st_reg.s1;
    st_next.s2_start_d = st_reg.s2.cycle_start;
    end_hs             = 1'b0;

    // dead-time counter counts up between phase changes and holds at its maximum
    if (st_reg.dt_cnt != `OCFH_DT_MAX)
      st_next.dt_cnt = st_reg.dt_cnt + 6'h01;

    // switching phases; every pulse also ends on overcurrent, in soft-start too
    unique case (st_reg.phase)
      OCFH_PH_IDLE: begin
        if (start_pulse && !st_reg.fault && !shut) begin
          st_next.phase    = OCFH_PH_DT_LH;
          st_next.low_drv  = 1'b0;
          st_next.dt_cnt   = 6'h00;
          st_next.dt_lh_late = 1'b0;
        end
      end
      OCFH_PH_DT_LH: begin
        // switch node rising before high side on means the delay was too long
        if (st_reg.s2.sw_high)
          st_next.dt_lh_late = 1'b1;
        if (st_reg.dt_cnt >= st_reg.dt_lh) begin
          st_next.phase    = OCFH_PH_HIGH;
          st_next.high_drv = 1'b1;
          st_next.hs_cycle = 1'b1;
          st_next.hs_width = 6'h00;
          // this cycle's measurement sets the next cycle's delay
          if (st_reg.dt_lh_late && st_reg.dt_lh > `OCFH_DT_MIN)
            st_next.dt_lh = st_reg.dt_lh - 6'h01;
          else if (!st_reg.dt_lh_late && st_reg.dt_lh < `OCFH_DT_MAX)
            st_next.dt_lh = st_reg.dt_lh + 6'h01;
        end
      end
      OCFH_PH_HIGH: begin
        if (st_reg.hs_width != `OCFH_DT_MAX)
          st_next.hs_width = st_reg.hs_width + 6'h01;
        if (st_reg.s2.overcurrent) begin
          st_next.oc_seen = 1'b1;
          end_hs          = 1'b1;
        end
        if (st_reg.s2.pwm_end || start_pulse)
          end_hs = 1'b1;
        if (end_hs) begin
          st_next.phase      = OCFH_PH_DT_HL;
          st_next.high_drv   = 1'b0;
          st_next.dt_cnt     = 6'h00;
          st_next.dt_hl_late = 1'b0;
          // hs_width lags the drive by one clock, so add it back before comparing
          st_next.narrow     = (32'(st_reg.hs_width) + 1 < MIN_PW_CYC);
        end
      end
      OCFH_PH_DT_HL: begin
        // switch node already low: body diode conducting, delay too long
        if (st_reg.s2.sw_low)
          st_next.dt_hl_late = 1'b1;
        if (st_reg.dt_cnt >= st_reg.dt_hl) begin
          st_next.phase   = OCFH_PH_LOW;
          st_next.low_drv = 1'b1;
          if (st_reg.dt_hl_late && st_reg.dt_hl > `OCFH_DT_MIN)
            st_next.dt_hl = st_reg.dt_hl - 6'h01;
          else if (!st_reg.dt_hl_late && st_reg.dt_hl < `OCFH_DT_MAX)
            st_next.dt_hl = st_reg.dt_hl + 6'h01;
        end
      end
      OCFH_PH_LOW: begin
        if (start_pulse) begin
          st_next.phase      = OCFH_PH_DT_LH;
          st_next.low_drv    = 1'b0;
          st_next.dt_cnt     = 6'h00;
          st_next.dt_lh_late = 1'b0;
        end
      end
      default: begin
        st_next.phase = OCFH_PH_IDLE;
      end
    endcase

    // one counter update per cycle, only outside soft-start
    if (start_pulse) begin
      st_next.oc_seen  = 1'b0;
      st_next.hs_cycle = 1'b0;
      if (st_reg.mode == OCFH_RUN && st_reg.hs_cycle) begin
        if (st_reg.oc_seen)
          st_next.count = cnt_up;
        else
          st_next.count = cnt_dn;
      end
    end

    // soft-start and hiccup sequencing
    unique case (st_reg.mode)
      OCFH_SOFTSTART: begin
        st_next.discharge = 1'b0;
        if (st_reg.s2.ss_done)
          st_next.mode = OCFH_RUN;
      end
      OCFH_RUN: begin
        if (st_reg.count == `OCFH_CNT_FULL) begin
          st_next.mode      = OCFH_DISCHARGE;
          st_next.fault     = 1'b1;
          st_next.discharge = 1'b1;
          st_next.count     = cnt_dn;
        end
      end
      OCFH_DISCHARGE: begin
        if (st_reg.s2.ss_empty) begin
          st_next.discharge = 1'b0;
          if (st_reg.count == `OCFH_CNT_ZERO) begin
            st_next.mode  = OCFH_SOFTSTART;
            st_next.fault = 1'b0;
          end else begin
            st_next.mode = OCFH_RECHARGE;
          end
        end
      end
      OCFH_RECHARGE: begin
        if (st_reg.s2.ss_peak) begin
          st_next.mode      = OCFH_DISCHARGE;
          st_next.discharge = 1'b1;
          st_next.count     = cnt_dn;
        end
      end
      default: begin
        st_next.mode = OCFH_SOFTSTART;
      end
    endcase

    // fault or external shutdown forces the drives off; shutdown outside fault restarts soft-start and clears the count
    if (st_next.fault || shut) begin
      st_next.phase    = OCFH_PH_IDLE;
      st_next.high_drv = 1'b0;
      st_next.low_drv  = 1'b0;
    end
    if (shut && !st_reg.fault) begin
      st_next.mode      = OCFH_SOFTSTART;
      st_next.count     = `OCFH_CNT_ZERO;
      st_next.discharge = 1'b0;
    end
    // registered copy of the soft-start mode so the output comes from a flop
    st_next.ss_active = (st_next.mode == OCFH_SOFTSTART);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg            <= '0;
      st_reg.mode       <= OCFH_SOFTSTART;
      st_reg.ss_active  <= 1'b1;
      st_reg.phase      <= OCFH_PH_IDLE;
      st_reg.dt_hl      <= `OCFH_DT_INIT;
      st_reg.dt_lh      <= `OCFH_DT_INIT;
      st_reg.s1.shutdown <= 1'b1;
      st_reg.s2.shutdown <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign high_side_gate_drive = st_reg.high_drv;
  assign low_side_gate_drive  = st_reg.low_drv;
  assign softstart_discharge  = st_reg.discharge;
  assign fault                = st_reg.fault;
  assign softstart_active     = st_reg.ss_active;
  assign narrow_pulse         = st_reg.narrow;
  assign oc_count             = st_reg.count;

endmodule : ocfh_core
`default_nettype wire

// *** design/ocfh_map.svh ***
// constants for the overcurrent fault and hiccup control block
`ifndef OCFH_MAP_SVH
`define OCFH_MAP_SVH
`define OCFH_CNT_W       3
`define OCFH_CNT_FULL    3'h7
`define OCFH_CNT_ZERO    3'h0
`define OCFH_CNT_ONE     3'h1
`define OCFH_MIN_PW_NS   150
`define OCFH_CLK_NS      10
`define OCFH_DT_W        6
`define OCFH_DT_INIT     6'h04
`define OCFH_DT_MAX      6'h3f
`define OCFH_DT_MIN      6'h01
`endif

// *** design/ocfh_pkg.sv ***
// types for the overcurrent fault and hiccup control block
`default_nettype none
`include "ocfh_map.svh"
package ocfh_pkg;
  typedef enum logic [1:0] {
    OCFH_RUN       = 2'b00,
    OCFH_SOFTSTART = 2'b01,
    OCFH_DISCHARGE = 2'b10,
    OCFH_RECHARGE  = 2'b11
  } ocfh_mode_t;

  typedef enum logic [2:0] {
    OCFH_PH_IDLE  = 3'b000,
    OCFH_PH_DT_LH = 3'b001,
    OCFH_PH_HIGH  = 3'b010,
    OCFH_PH_DT_HL = 3'b011,
    OCFH_PH_LOW   = 3'b100
  } ocfh_phase_t;

  // sampled analog comparator levels, after synchronisation
  typedef struct packed {
    logic cycle_start;
    logic pwm_end;
    logic overcurrent;
    logic ss_empty;
    logic ss_peak;
    logic ss_done;
    logic sw_low;
    logic sw_high;
    logic shutdown;
  } ocfh_sense_t;

  typedef struct packed {
    ocfh_mode_t                  mode;
    ocfh_phase_t                 phase;
    logic [`OCFH_CNT_W-1:0]      count;
    logic                        oc_seen;
    logic                        hs_cycle;
    logic [`OCFH_DT_W-1:0]       dt_hl;
    logic [`OCFH_DT_W-1:0]       dt_lh;
    logic [`OCFH_DT_W-1:0]       dt_cnt;
    logic [`OCFH_DT_W-1:0]       hs_width;
    logic                        dt_hl_late;
    logic                        dt_lh_late;
    logic                        high_drv;
    logic                        low_drv;
    logic                        discharge;
    logic                        fault;
    logic                        narrow;
    logic                        ss_active;
    ocfh_sense_t                 s1;
    ocfh_sense_t                 s2;
    logic                        s2_start_d;
  } ocfh_state_t;
endpackage : ocfh_pkg
`default_nettype wire

// *** tb/ocfh_props.sv ***
// assertion checker for the overcurrent fault and hiccup block
`default_nettype none
module ocfh_props #(
  parameter int CNT_W = 3
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             overcurrent,
  input wire logic             softstart_cap_empty,
  input wire logic             high_side_gate_drive,
  input wire logic             low_side_gate_drive,
  input wire logic             softstart_discharge,
  input wire logic             fault,
  input wire logic             softstart_active,
  input wire logic [CNT_W-1:0] oc_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // one update per cycle, so the count rests afterwards
  sequence s_hold;
    $stable(oc_count) [*8];
  endsequence
  sequence s_entry;
    $rose(fault) && $past(oc_count) == 3'h7;
  endsequence
  chk_no_wrap: assert property ($past(oc_count) == 3'h0 |-> oc_count <= 3'h1)
    else $error("counter wrapped below zero");
  chk_full_fault: assert property (oc_count == 3'h7 && !fault |=> fault)
    else $error("full count without fault");
  chk_fault_entry: assert property (s_entry |-> oc_count == 3'h6 && softstart_discharge)
    else $error("fault entry without discharge and decrement");
  chk_drives_off: assert property (fault |-> !high_side_gate_drive && !low_side_gate_drive)
    else $error("gate drive on during fault");
  chk_peak_dec: assert property ($rose(softstart_discharge) && $past(fault) |-> oc_count == $past(oc_count) - 3'h1)
    else $error("retry discharge without decrement");
  chk_empty_stop: assert property (fault && softstart_discharge && softstart_cap_empty |-> ##[1:4] !softstart_discharge)
    else $error("discharge kept on at empty cap");
  chk_fault_clear: assert property ($fell(fault) |-> oc_count == 3'h0 && softstart_active)
    else $error("fault cleared without zero count and soft-start");
  chk_ss_blank: assert property (softstart_active && $past(softstart_active) |-> oc_count <= $past(oc_count))
    else $error("count rose during soft-start");
  chk_one_update: assert property ($changed(oc_count) && oc_count != 3'h7 |=> s_hold)
    else $error("two count updates too close");
  chk_oc_cut: assert property (overcurrent && high_side_gate_drive |-> ##[1:5] !high_side_gate_drive)
    else $error("pulse not ended on overcurrent");
endmodule : ocfh_props
bind ocfh_core ocfh_props #(.CNT_W(CNT_W)) u_props (
  .clk(clk), .nrst(nrst), .overcurrent(overcurrent), .softstart_cap_empty(softstart_cap_empty),
  .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive),
  .softstart_discharge(softstart_discharge), .fault(fault), .softstart_active(softstart_active),
  .oc_count(oc_count)
);
`default_nettype wire

// *** tb/ocfh_plant.sv ***
// behavioural power stage and soft-start capacitor
`default_nettype none
module ocfh_plant (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic high_side_gate_drive,
  input  wire logic softstart_discharge,
  output logic      softstart_cap_empty,
  output logic      softstart_cap_peak,
  output logic      softstart_cap_done,
  output logic      switch_node_low,
  output logic      switch_node_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl  = 8'h00;
  logic       hs_d = 1'b0;
  // slow ramp, fast dump, so a retry spans more than one switching cycle
  always @(posedge clk) begin
    if (!nrst) lvl <= 8'h00;
    else if (softstart_discharge) lvl <= (lvl > 8'h10) ? lvl - 8'h10 : 8'h00;
    else if (lvl != 8'hff) lvl <= lvl + 8'h01;
  end
  // node lags the top switch by a clock, like a real edge
  always @(posedge clk) begin
    hs_d <= high_side_gate_drive;
  end
  assign switch_node_high    = hs_d;
  assign switch_node_low     = !hs_d;
  assign softstart_cap_empty = (lvl == 8'h00);
  assign softstart_cap_peak  = (lvl >= 8'ha0);
  assign softstart_cap_done  = (lvl == 8'hff);
endmodule : ocfh_plant
`default_nettype wire

// *** tb/tb_overcurrent_fault_hiccup_control.sv ***
// self-checking bench for the overcurrent fault and hiccup block
`default_nettype none
module tb_overcurrent_fault_hiccup_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, cs, pe, oc, sd, emp, pk, dn, swl, swh, hd, ld, dis, flt, ssa, nar;
  logic [2:0]  cnt, exp_cnt;
  logic        last_oc;
  logic        dis_d = 1'b0;
  logic [31:0] lfsr;
  int          n_fail, checks, n_dis;
  int          hd_run = 0;
  int          last_w = 100;
  ocfh_core DUT (.clk(clk), .nrst(nrst), .cycle_start(cs), .pwm_end(pe), .overcurrent(oc),
    .softstart_cap_empty(emp), .softstart_cap_peak(pk), .softstart_cap_done(dn),
    .switch_node_low(swl), .switch_node_high(swh), .softstart_shutdown_pin(sd),
    .high_side_gate_drive(hd), .low_side_gate_drive(ld), .softstart_discharge(dis),
    .fault(flt), .softstart_active(ssa), .narrow_pulse(nar), .oc_count(cnt));
  ocfh_plant u_plant (.clk(clk), .nrst(nrst), .high_side_gate_drive(hd), .softstart_discharge(dis),
    .softstart_cap_empty(emp), .softstart_cap_peak(pk), .softstart_cap_done(dn),
    .switch_node_low(swl), .switch_node_high(swh));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [2:0] sat(input logic [2:0] c, input logic up);
    if (up) return (c == 3'h7) ? c : c + 3'h1;
    return (c == 3'h0) ? c : c - 3'h1;
  endfunction : sat
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // one 100-clock switching cycle, checking the previous cycle's update
  task automatic run_cycle(input logic o, input logic chk);
    cs <= 1'b1;
    tick(2);
    cs <= 1'b0;
    tick(6);
    if (chk) begin
      cmp(8'(nar), 8'(last_w * 10 < 150));
      exp_cnt = sat(exp_cnt, last_oc);
      if (exp_cnt == 3'h7) begin
        cmp(8'(flt), 8'h1);
        cmp(8'(cnt), 8'h6);
        exp_cnt = 3'h6;
      end else
        cmp(8'(cnt), 8'(exp_cnt));
    end
    last_oc = o;
    tick(67);
    oc <= o;
    tick(10);
    oc <= 1'b0;
    pe <= 1'b1;
    tick(12);
    pe <= 1'b0;
    tick(3);
  endtask : run_cycle
  // corner case: pulse ended by the modulator a few clocks after the top switch turns on
  task automatic short_cycle();
    cs <= 1'b1;
    tick(2);
    cs <= 1'b0;
    while (!hd) tick(1);
    pe <= 1'b1;
    tick(4);
    pe <= 1'b0;
    tick(80);
  endtask : short_cycle
  // width of the last top-switch pulse in clocks, measured at the pin
  always @(posedge clk) begin
    if (hd) hd_run <= hd_run + 1;
    else if (hd_run != 0) begin
      last_w <= hd_run;
      hd_run <= 0;
    end
  end
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // discharge starts seen over the whole retry
  always @(posedge clk) begin
    if (dis && !dis_d) n_dis <= n_dis + 1;
    dis_d <= dis;
  end
  // hang guard, well past the planned run
  initial begin
    tick(10000);
    n_fail++;
    end_sim();
  end
  // main sequence
  initial begin
    nrst = 1'b0; cs = 1'b0; pe = 1'b0; oc = 1'b0; sd = 1'b1;
    exp_cnt = 3'h0; last_oc = 1'b0; lfsr = 32'h90ed; n_dis = 0;
    tick(4);
    nrst <= 1'b1;
    repeat (2) run_cycle(1'b1, 1'b0);
    last_oc = 1'b0;
    repeat (2) run_cycle(1'b0, 1'b1);
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      run_cycle(lfsr[0] && sat(exp_cnt, last_oc) < 3'h5, 1'b1);
    end
    n_dis = 0;
    for (int i = 0; i < 10 && !flt; i++) run_cycle(1'b1, 1'b1);
    for (int i = 0; i < 40 && flt; i++) run_cycle(1'b1, 1'b0);
    cmp(8'(n_dis), 8'h7);
    cmp({4'h0, flt, ssa, cnt[1:0]}, 8'h4);
    run_cycle(1'b1, 1'b0);
    last_oc = 1'b0;
    exp_cnt = 3'h0;
    repeat (2) run_cycle(1'b0, 1'b1);
    short_cycle();
    run_cycle(1'b1, 1'b1);
    run_cycle(1'b0, 1'b1);
    sd <= 1'b0;
    tick(10);
    cmp({5'h0, cnt}, 8'h0);
    cmp({6'h0, hd, ld}, 8'h0);
    sd <= 1'b1;
    end_sim();
  end
endmodule : tb_overcurrent_fault_hiccup_control
`default_nettype wire
